/* File: address_generator.sv */
// bit-reversed write address generation and table/program space access
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module address_generator
   import agu_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int PM_W = 24
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire agu_req_t agu_req_i,
   output agu_resp_t agu_resp_o,
   input wire tbl_req_t tbl_req_i,
   output tbl_resp_t tbl_resp_o,
   output pm_cmd_t pm_o,
   input wire logic [23:0] pm_rdata_i,
   input wire logic pc_advance_i,
   input wire logic pc_load_i,
   input wire logic [22:0] pc_value_i,
   output logic [23:0] program_counter_o
);

   // lanes are fixed by the carriers; other widths cannot be served
   if (DATA_W != 16 || PM_W != 24) begin : g_width_check
      $error("address_generator supports only 16-bit data and 24-bit program words");
   end

   // ************************************************************
   // software registers
   // ************************************************************
   logic [15:0] bit_reverse_control;
   logic [7:0] table_page;
   logic [15:0] addressing_mode_control;
   logic [15:0] last_ea;
   logic [23:0] last_pa;
   logic wb_hit;
   logic [31:0] next_rdata;

   assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // one wait state: ack rises the cycle after the strobe, then drops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
      end
   end

   // byte enables honoured on the two low lanes only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_reverse_control <= BREV_RST;
         table_page <= PAGE_RST;
         addressing_mode_control <= MODE_RST;
      end else if (wb_hit && wb_we_i) begin
         unique case (wb_adr_i)
            OFS_BREV: begin
               if (wb_sel_i[0]) bit_reverse_control[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) bit_reverse_control[15:8] <= wb_dat_i[15:8];
            end
            OFS_PAGE: begin
               if (wb_sel_i[0]) table_page <= wb_dat_i[7:0];
            end
            OFS_MODE: begin
               if (wb_sel_i[0]) addressing_mode_control[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) addressing_mode_control[15:8] <= wb_dat_i[15:8];
            end
            default: begin
            end
         endcase
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = 32'h00000000;
      unique case (wb_adr_i)
         OFS_BREV: next_rdata[15:0] = bit_reverse_control;
         OFS_PAGE: next_rdata[7:0] = table_page;
         OFS_MODE: next_rdata[15:0] = addressing_mode_control;
         OFS_LAST_EA: next_rdata[15:0] = last_ea;
         OFS_LAST_PA: next_rdata[23:0] = last_pa;
         default: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (wb_hit) begin
         wb_dat_o <= next_rdata;
      end
   end

   // ************************************************************
   // bit-reversed write address generation
   // ************************************************************
   logic reverse_enable;
   logic [SEL_W-1:0] reverse_pointer_select;
   logic [PIVOT_W-1:0] reverse_pivot;
   logic [PIVOT_W-1:0] ptr_index;
   logic [PIVOT_W-1:0] ptr_mirror;
   logic [PIVOT_W-1:0] pivot_mirror;
   logic [PIVOT_W-1:0] sum_mirror;
   logic [PIVOT_W-1:0] next_index;
   logic rev_active;
   logic [15:0] rev_next;
   logic [15:0] step_up;
   logic [15:0] step_down;
   agu_resp_t next_agu;

   assign reverse_enable = bit_reverse_control[BREV_EN_BIT];
   assign reverse_pivot = bit_reverse_control[PIVOT_W-1:0];
   assign reverse_pointer_select = addressing_mode_control[SEL_W-1:0];
   // word index: pointer lsb dropped, pivot taken in words
   assign ptr_index = agu_req_i.pointer[15:1];

   // mirror pointer and pivot, add, mirror back: carries run downward
   for (genvar i = 0; i < PIVOT_W; i++) begin : g_mirror
      assign ptr_mirror[i] = ptr_index[PIVOT_W-1-i];
      assign pivot_mirror[i] = reverse_pivot[PIVOT_W-1-i];
      assign next_index[i] = sum_mirror[PIVOT_W-1-i];
   end
   // carry out of the mirrored msb is the wrap of the buffer
   assign sum_mirror = ptr_mirror + pivot_mirror;
   // next index scaled to bytes, lsb forced clear
   assign rev_next = {next_index, 1'b0};

   // only indirect increments of word writes through the chosen pointer
   assign rev_active = agu_req_i.valid & agu_req_i.is_write
                     & ~agu_req_i.is_byte
                     & reverse_enable
                     & (reverse_pointer_select != SEL_NONE)
                     & (reverse_pointer_select == agu_req_i.wreg)
                     & (agu_req_i.mode == AM_POST_INC || agu_req_i.mode == AM_PRE_INC);

   assign step_up = agu_req_i.pointer + agu_req_i.offset;
   assign step_down = agu_req_i.pointer - agu_req_i.offset;

   // effective address and pointer writeback
   always_comb begin
      next_agu = '0;
      next_agu.valid = agu_req_i.valid;
      next_agu.reversed = rev_active;
      // modulo correction is suppressed when reversal owns the pointer
      next_agu.modulo_apply = agu_req_i.valid & agu_req_i.modulo_en & ~rev_active;
      next_agu.ea = agu_req_i.pointer;
      next_agu.writeback = agu_req_i.pointer;
      if (rev_active) begin
         // mode offset ignored, pivot used instead
         next_agu.writeback = rev_next;
         if (agu_req_i.mode == AM_PRE_INC) begin
            next_agu.ea = rev_next;
         end else begin
            next_agu.ea = {agu_req_i.pointer[15:1], 1'b0};
         end
      end else begin
         // ordinary addressing, reads included
         unique case (agu_req_i.mode)
            AM_INDIRECT: begin
            end
            AM_POST_INC: next_agu.writeback = step_up;
            AM_POST_DEC: next_agu.writeback = step_down;
            AM_PRE_INC: begin
               next_agu.ea = step_up;
               next_agu.writeback = step_up;
            end
            AM_PRE_DEC: begin
               next_agu.ea = step_down;
               next_agu.writeback = step_down;
            end
            AM_INDEXED: next_agu.ea = step_up;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         agu_resp_o <= '0;
      end else begin
         agu_resp_o <= next_agu;
      end
   end

   // last effective address, visible to software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_ea <= 16'h0000;
      end else if (agu_req_i.valid) begin
         last_ea <= next_agu.ea;
      end
   end

   // ************************************************************
   // table and window access to program memory
   // ************************************************************
   logic is_window;
   logic is_write;
   logic byte_sel;
   logic [23:0] next_pa;
   logic [2:0] next_lanes;
   logic [23:0] next_wdata;
   logic refuse;
   logic pend;
   logic pend_refused;
   tbl_op_t pend_op;
   logic pend_byte;
   logic pend_sel;
   logic [23:0] pend_pa;
   logic [15:0] next_tdata;

   assign is_window = (tbl_req_i.op == OP_WIN_READ) || (tbl_req_i.op == OP_WIN_WRITE);
   assign is_write = (tbl_req_i.op == OP_WRITE_LOW) || (tbl_req_i.op == OP_WRITE_HIGH);
   // any alignment taken: lsb becomes the byte select
   assign byte_sel = tbl_req_i.ea[0];
   // window writes are dropped and flagged
   assign refuse = tbl_req_i.op == OP_WIN_WRITE;

   // program address: page over ea, lsb held zero
   always_comb begin
      if (is_window) begin
         next_pa = {addressing_mode_control[15:WIN_PAGE_LSB], tbl_req_i.ea[14:0], 1'b0};
      end else begin
         next_pa = {table_page, tbl_req_i.ea[15:1], 1'b0};
      end
   end

   // write lanes of the 24-bit word; phantom byte writes nothing
   always_comb begin
      next_lanes = 3'b000;
      next_wdata = 24'h000000;
      unique case (tbl_req_i.op)
         OP_WRITE_LOW: begin
            if (!tbl_req_i.byte_mode) begin
               next_lanes = 3'b011;
               next_wdata[15:0] = tbl_req_i.wdata;
            end else if (byte_sel) begin
               next_lanes = 3'b010;
               next_wdata[15:8] = tbl_req_i.wdata[7:0];
            end else begin
               next_lanes = 3'b001;
               next_wdata[7:0] = tbl_req_i.wdata[7:0];
            end
         end
         OP_WRITE_HIGH: begin
            if (!tbl_req_i.byte_mode || !byte_sel) begin
               next_lanes = 3'b100;
               next_wdata[23:16] = tbl_req_i.wdata[7:0];
            end
         end
         default: begin
         end
      endcase
   end

   // memory strobe one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pm_o <= '0;
      end else begin
         pm_o.rd <= tbl_req_i.valid & ~is_write & ~refuse;
         pm_o.wr <= tbl_req_i.valid & is_write;
         pm_o.lanes <= next_lanes;
         pm_o.addr <= next_pa;
         pm_o.wdata <= next_wdata;
      end
   end

   // context held for the returning word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend <= 1'b0;
         pend_refused <= 1'b0;
         pend_op <= OP_READ_LOW;
         pend_byte <= 1'b0;
         pend_sel <= 1'b0;
         pend_pa <= 24'h000000;
      end else begin
         pend <= tbl_req_i.valid;
         pend_refused <= tbl_req_i.valid & refuse;
         pend_op <= tbl_req_i.op;
         pend_byte <= tbl_req_i.byte_mode & ~is_window;
         pend_sel <= byte_sel;
         pend_pa <= next_pa;
      end
   end

   // lane mapping of returned program word into data word
   always_comb begin
      next_tdata = 16'h0000;
      unique case (pend_op)
         OP_READ_LOW, OP_WIN_READ: begin
            if (!pend_byte) begin
               next_tdata = pm_rdata_i[15:0];
            end else if (pend_sel) begin
               next_tdata[7:0] = pm_rdata_i[15:8];
            end else begin
               next_tdata[7:0] = pm_rdata_i[7:0];
            end
         end
         OP_READ_HIGH: begin
            // phantom byte always reads zero
            if (!pend_byte || !pend_sel) begin
               next_tdata[7:0] = pm_rdata_i[23:16];
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tbl_resp_o <= '0;
      end else begin
         tbl_resp_o.valid <= pend;
         tbl_resp_o.refused <= pend_refused;
         tbl_resp_o.config_space <= pend_pa[PAGE_CFG_BIT+16];
         tbl_resp_o.prog_addr <= pend_pa;
         tbl_resp_o.rdata <= next_tdata;
      end
   end

   // last program address, visible to software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_pa <= 24'h000000;
      end else if (tbl_req_i.valid) begin
         last_pa <= next_pa;
      end
   end

   // ************************************************************
   // program counter
   // ************************************************************
   logic [22:0] pc;

   // user space only: bit 23 and bit 0 stay zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc <= PC_RST;
      end else if (pc_load_i) begin
         pc <= {pc_value_i[22:1], 1'b0};
      end else if (pc_advance_i) begin
         pc <= pc + PC_STEP;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         program_counter_o <= 24'h000000;
      end else begin
         program_counter_o <= {1'b0, pc};
      end
   end

endmodule : address_generator
`default_nettype wire

/* File: agu_pkg.sv */
// package of constants and carriers for the address generation block
package agu_pkg;

   // ************************************************************
   // register map (wishbone byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_BREV = 8'h00;
   localparam logic [7:0] OFS_PAGE = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_LAST_EA = 8'h0c;
   localparam logic [7:0] OFS_LAST_PA = 8'h10;

   // ************************************************************
   // field layout and reset values
   // ************************************************************
   localparam int BREV_EN_BIT = 15;
   localparam int PIVOT_W = 15;
   localparam int SEL_W = 4;
   localparam int PAGE_W = 8;
   localparam int PAGE_CFG_BIT = 7;
   localparam int WIN_PAGE_LSB = 8;
   localparam logic [SEL_W-1:0] SEL_NONE = 4'hf;
   localparam logic [15:0] BREV_RST = 16'h0000;
   localparam logic [7:0] PAGE_RST = 8'h00;
   localparam logic [15:0] MODE_RST = 16'h000f;
   localparam logic [22:0] PC_STEP = 23'h000002;
   localparam logic [22:0] PC_RST = 23'h000000;

   // ************************************************************
   // modes, operations and carriers
   // ************************************************************
   typedef enum logic [2:0] {
      AM_INDIRECT = 3'b000,
      AM_POST_INC = 3'b001,
      AM_POST_DEC = 3'b010,
      AM_PRE_INC = 3'b011,
      AM_PRE_DEC = 3'b100,
      AM_INDEXED = 3'b101
   } addr_mode_t;

   typedef enum logic [2:0] {
      OP_READ_LOW = 3'b000,
      OP_READ_HIGH = 3'b001,
      OP_WRITE_LOW = 3'b010,
      OP_WRITE_HIGH = 3'b011,
      OP_WIN_READ = 3'b100,
      OP_WIN_WRITE = 3'b101
   } tbl_op_t;

   typedef struct packed {
      logic valid;
      logic is_write;
      logic is_byte;
      logic modulo_en;
      addr_mode_t mode;
      logic [3:0] wreg;
      logic [15:0] pointer;
      logic [15:0] offset;
   } agu_req_t;

   typedef struct packed {
      logic valid;
      logic reversed;
      logic modulo_apply;
      logic [15:0] ea;
      logic [15:0] writeback;
   } agu_resp_t;

   typedef struct packed {
      logic valid;
      tbl_op_t op;
      logic byte_mode;
      logic [15:0] ea;
      logic [15:0] wdata;
   } tbl_req_t;

   typedef struct packed {
      logic valid;
      logic refused;
      logic config_space;
      logic [23:0] prog_addr;
      logic [15:0] rdata;
   } tbl_resp_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] lanes;
      logic [23:0] addr;
      logic [23:0] wdata;
   } pm_cmd_t;

endpackage : agu_pkg

/* File: pm_model.sv */
// behavioural program memory facing the address generator
`timescale 1ns/100ps
`default_nettype none
module pm_model
   import agu_pkg::*;
(
   input wire logic clk_i,
   input wire pm_cmd_t pm_i,
   output logic [23:0] pm_rdata_o
);
   // ************
   // read port
   // ************
   logic [23:0] last = 24'h000000;

   // fixed content pattern so every address has its own 24-bit word
   function automatic logic [23:0] pm_word(input logic [23:0] a);
      return {a[23:16] ^ 8'hc3, a[15:0] ^ 16'h5aa5};
   endfunction : pm_word

   // idle bus shows the inverted last word, never a stale copy
   assign pm_rdata_o = pm_i.rd ? pm_word(pm_i.addr) : ~last;

   // remember the last word driven
   always @(posedge clk_i) begin
      if (pm_i.rd) begin
         last <= pm_word(pm_i.addr);
      end
   end
endmodule : pm_model
`default_nettype wire

/* File: addr_gen_chk.sv */
// port checker for the address generator
`timescale 1ns/100ps
`default_nettype none
module addr_gen_chk
   import agu_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire agu_req_t agu_req_i,
   input wire agu_resp_t agu_resp_o,
   input wire tbl_req_t tbl_req_i,
   input wire tbl_resp_t tbl_resp_o,
   input wire pm_cmd_t pm_o,
   input wire logic pc_advance_i,
   input wire logic pc_load_i,
   input wire logic [23:0] program_counter_o
);
   // ************
   // relations
   // ************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_read_not_rev: assert property (agu_req_i.valid && !agu_req_i.is_write |=> !agu_resp_o.reversed)
      else $error("read got a reversed address");
   a_byte_not_rev: assert property (agu_req_i.valid && agu_req_i.is_byte |=> !agu_resp_o.reversed)
      else $error("byte access got a reversed address");
   a_mode_not_rev: assert property (agu_req_i.valid && !(agu_req_i.mode inside {AM_POST_INC, AM_PRE_INC})
      |=> !agu_resp_o.reversed)
      else $error("reversal outside increment modes");
   a_rev_word_lsb: assert property (agu_resp_o.reversed |-> !agu_resp_o.ea[0] && !agu_resp_o.writeback[0])
      else $error("reversed address lsb set");
   a_rev_over_mod: assert property (agu_resp_o.reversed |-> !agu_resp_o.modulo_apply)
      else $error("modulo applied to a reversed write");
   a_post_ea_plain: assert property (agu_req_i.valid && agu_req_i.mode == AM_POST_INC ##1 agu_resp_o.reversed
      |-> agu_resp_o.ea[15:1] == $past(agu_req_i.pointer[15:1]))
      else $error("post increment address not in normal order");
   a_pm_addr_lsb: assert property (pm_o.rd || pm_o.wr |-> !pm_o.addr[0])
      else $error("program address lsb set");
   a_tbl_ea_map: assert property (tbl_req_i.valid && tbl_req_i.op inside {OP_READ_LOW, OP_READ_HIGH}
      |=> pm_o.rd && pm_o.addr[15:1] == $past(tbl_req_i.ea[15:1]))
      else $error("table read address wrong");
   a_win_refused: assert property (tbl_req_i.valid && tbl_req_i.op == OP_WIN_WRITE
      |=> !pm_o.wr && !pm_o.rd ##1 tbl_resp_o.valid && tbl_resp_o.refused)
      else $error("window write not refused");
   // the counter output trails the counter itself by one flop, hence two cycles
   a_pc_step_two: assert property (pc_advance_i && !pc_load_i
      |-> ##2 program_counter_o == $past(program_counter_o) + 24'h000002)
      else $error("program counter step not two");

   // main scenarios reached
   c_reversed: cover property (agu_resp_o.reversed);
   c_refused: cover property (tbl_resp_o.refused);
   c_config: cover property (tbl_resp_o.valid && tbl_resp_o.config_space);
endmodule : addr_gen_chk

bind address_generator addr_gen_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .agu_req_i(agu_req_i),
   .agu_resp_o(agu_resp_o), .tbl_req_i(tbl_req_i), .tbl_resp_o(tbl_resp_o), .pm_o(pm_o),
   .pc_advance_i(pc_advance_i), .pc_load_i(pc_load_i), .program_counter_o(program_counter_o));
`default_nettype wire

/* File: address_generator_bench.sv */
// self-checking bench for the address generator
`timescale 1ns/100ps
`default_nettype none
module address_generator_bench;
   import agu_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   agu_req_t agu_req_i = '0;
   agu_resp_t agu_resp_o;
   tbl_req_t tbl_req_i = '0;
   tbl_resp_t tbl_resp_o;
   pm_cmd_t pm_o;
   logic [23:0] pm_rdata_i;
   logic pc_advance_i = 1'b0;
   logic pc_load_i = 1'b0;
   logic [22:0] pc_value_i = 23'h0;
   logic [23:0] program_counter_o;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;

   always #50 clk_i = ~clk_i;

   // only lanes 0 and 1 carry writable register bits
   address_generator dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .agu_req_i(agu_req_i), .agu_resp_o(agu_resp_o), .tbl_req_i(tbl_req_i),
      .tbl_resp_o(tbl_resp_o), .pm_o(pm_o), .pm_rdata_i(pm_rdata_i), .pc_advance_i(pc_advance_i),
      .pc_load_i(pc_load_i), .pc_value_i(pc_value_i), .program_counter_o(program_counter_o));
   pm_model pm_u (.clk_i(clk_i), .pm_i(pm_o), .pm_rdata_o(pm_rdata_i));

   // ************
   // shared tasks
   // ************
   // hang guard, the run needs under two hundred cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   // classic cycle, held until ack is sampled
   task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb_access

   task automatic agu_op(input logic wr, input logic byt, input addr_mode_t md, input logic [3:0] wreg,
      input logic [15:0] ptr, output agu_resp_t r);
      agu_req_i <= '{1'b1, wr, byt, 1'b1, md, wreg, ptr, 16'h0006};
      @(posedge clk_i);
      agu_req_i.valid <= 1'b0;
      @(posedge clk_i);
      r = agu_resp_o;
   endtask : agu_op

   task automatic tbl_op(input tbl_op_t op, input logic bm, input logic [15:0] ea, output pm_cmd_t c,
      output tbl_resp_t r);
      tbl_req_i <= '{1'b1, op, bm, ea, 16'hbeef};
      @(posedge clk_i);
      tbl_req_i.valid <= 1'b0;
      @(posedge clk_i);
      c = pm_o;
      @(posedge clk_i);
      r = tbl_resp_o;
   endtask : tbl_op

   function automatic logic [15:0] exp_rd(input logic hi, input logic bm, input logic sel, input logic [23:0] w);
      if (!hi) begin
         return bm ? {8'h00, sel ? w[15:8] : w[7:0]} : w[15:0];
      end
      return (bm && sel) ? 16'h0000 : {8'h00, w[23:16]};
   endfunction : exp_rd

   // ************
   // scenarios
   // ************
   task automatic t_regs();
      logic [31:0] rd;
      logic [7:0] adr [4] = '{OFS_BREV, OFS_PAGE, OFS_MODE, 8'h20};
      logic [31:0] exp [4] = '{32'h0, 32'h0, 32'h0000_000f, 32'h0};
      wb_access(1'b1, 8'h20, 32'hffff_ffff, rd);
      for (int i = 0; i < 4; i++) begin
         wb_access(1'b0, adr[i], 32'h0, rd);
         check("register reset", rd, exp[i]);
      end
   endtask : t_regs

   task automatic t_bitrev();
      agu_resp_t r;
      logic [31:0] rd;
      logic [15:0] ptr;
      logic [15:0] nxt;
      wb_access(1'b1, OFS_MODE, 32'h0000_0003, rd);
      wb_access(1'b1, OFS_BREV, 32'h0000_8008, rd);
      ptr = 16'h0100;
      // only writes follow the control write, no reverse-pointer read
      for (int i = 1; i < 16; i++) begin
         nxt = 16'h0100 | {11'h000, i[0], i[1], i[2], i[3], 1'b0};
         agu_op(1'b1, 1'b0, AM_PRE_INC, 4'h3, ptr, r);
         check("reversed ea", 32'(r.ea), 32'(nxt));
         check("reversed writeback", 32'(r.writeback), 32'(nxt));
         check("reversed flags", 32'({r.valid, r.reversed, r.modulo_apply}), 32'h6);
         ptr = nxt;
      end
      agu_op(1'b1, 1'b0, AM_POST_INC, 4'h3, 16'h0115, r);
      check("post ea", 32'(r.ea), 32'h0114);
      check("post writeback", 32'(r.writeback), 32'h010c);
      // software view of the last effective address
      wb_access(1'b0, OFS_LAST_EA, 32'h0, rd);
      check("last ea", rd, 32'h0000_0114);
   endtask : t_bitrev

   task automatic t_norev();
      agu_resp_t r;
      logic [31:0] rd;
      // byte write, read, other mode, other pointer
      for (int i = 0; i < 4; i++) begin
         agu_op(i != 1, i == 0, i == 2 ? AM_POST_DEC : AM_PRE_INC, i == 3 ? 4'h4 : 4'h3, 16'h0200, r);
         check("plain ea", 32'(r.ea), i == 2 ? 32'h0200 : 32'h0206);
         check("plain flags", 32'({r.valid, r.reversed, r.modulo_apply}), 32'h5);
      end
      wb_access(1'b1, OFS_MODE, 32'h0000_000f, rd);
      agu_op(1'b1, 1'b0, AM_PRE_INC, 4'hf, 16'h0200, r);
      check("no select ea", 32'({r.reversed, r.ea}), 32'h0206);
   endtask : t_norev

   task automatic t_table();
      pm_cmd_t c;
      tbl_resp_t r;
      logic [31:0] rd;
      logic [23:0] w;
      wb_access(1'b1, OFS_PAGE, 32'hffff_ff85, rd);
      wb_access(1'b0, OFS_PAGE, 32'h0, rd);
      check("page readback", rd, 32'h0000_0085);
      w = pm_u.pm_word(24'h851234);
      for (int i = 0; i < 8; i++) begin
         tbl_op(i[2] ? OP_READ_HIGH : OP_READ_LOW, i[1], 16'h1234 | 16'(i[0]), c, r);
         check("table address", 32'(c.addr), 32'h0085_1234);
         check("response address", 32'(r.prog_addr), 32'h0085_1234);
         check("table space", 32'({r.valid, r.config_space}), 32'h3);
         check("table data", 32'(r.rdata), 32'(exp_rd(i[2], i[1], i[0], w)));
      end
      wb_access(1'b1, OFS_PAGE, 32'h0000_0005, rd);
      tbl_op(OP_READ_LOW, 1'b0, 16'h1234, c, r);
      check("user space", 32'({c.addr, r.config_space}), 32'({24'h051234, 1'b0}));
      check("user word", 32'(r.rdata), 32'(pm_u.pm_word(24'h051234) & 24'h00ffff));
      tbl_op(OP_WRITE_LOW, 1'b0, 16'h2000, c, r);
      check("table write", 32'({c.wr, c.lanes, c.wdata[15:0]}), 32'({1'b1, 3'b011, 16'hbeef}));
      wb_access(1'b1, OFS_MODE, 32'h0000_120f, rd);
      tbl_op(OP_WIN_READ, 1'b1, 16'h8035, c, r);
      check("window address", 32'(c.addr), 32'h0012_006a);
      check("window data", 32'(r.rdata), 32'(pm_u.pm_word(24'h12006a) & 24'h00ffff));
      tbl_op(OP_WIN_WRITE, 1'b0, 16'h8034, c, r);
      check("window write", 32'({c.rd, c.wr, r.refused}), 32'h1);
      // the refused write still records its program address
      wb_access(1'b0, OFS_LAST_PA, 32'h0, rd);
      check("last program address", rd, 32'h0012_0068);
   endtask : t_table

   task automatic t_pc();
      pc_load_i <= 1'b1;
      pc_value_i <= 23'h000011;
      @(posedge clk_i);
      pc_load_i <= 1'b0;
      pc_advance_i <= 1'b1;
      @(posedge clk_i);
      pc_advance_i <= 1'b0;
      // output flop trails the counter by one cycle
      @(posedge clk_i);
      check("pc load", 32'(program_counter_o), 32'h10);
      @(posedge clk_i);
      check("pc step", 32'(program_counter_o), 32'h12);
      pc_load_i <= 1'b1;
      pc_advance_i <= 1'b1;
      pc_value_i <= 23'h000100;
      @(posedge clk_i);
      pc_load_i <= 1'b0;
      pc_advance_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("pc load wins", 32'(program_counter_o), 32'h100);
   endtask : t_pc

   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_bitrev();
      t_norev();
      t_table();
      t_pc();
      print_verdict();
   end
endmodule : address_generator_bench
`default_nettype wire
